// [rtl/region_protection_translation.sv]
// protection unit top: apb registers, protected-mode control, access gating
`include "region_protection_defines.svh"
module region_protection_translation
	import region_protection_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input wire logic pclk, // processor clock
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic acc_valid, // core issues an access this cycle
	input wire logic [31:0] acc_addr, // logical address of access
	input wire access_kind_e acc_kind, // read, write or fetch
	input wire logic ws_check_valid, // workspace pointer just moved
	input wire logic [31:0] workspace_pointer, // new workspace pointer
	input wire logic breakpoint_jump, // breakpoint instruction executed
	input wire logic step_done, // single-stepped instruction completed
	input wire logic watch_write, // write hit the watchpoint region
	input wire logic state_saved, // core finished saving process state
	output logic mem_valid, // physical access forwarded to memory
	output logic [31:0] mem_addr, // physical address
	output access_kind_e mem_kind, // kind of forwarded access
	output logic acc_fault, // access refused, pulse
	output logic protected_mode, // protected process running
	output logic trap_req, // save state and leave protected mode
	output trap_cause_e trap_cause, // reason of the current trap
	output logic [31:0] trap_state_ptr, // where to save process state
	output logic resume_supervisor, // resume supervisor, pulse
	output logic [31:0] resume_wdesc // supervisor to resume
);
	if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad
		$error("region_protection_translation: COUNT_W must be 1 to 32");
	end

	// register state
	logic [3:0][31:0] desc_reg, desc_next;
	logic [31:0] state_ptr_reg, state_ptr_next;
	logic [31:0] sup_wdesc_reg, sup_wdesc_next;
	logic [31:0] fault_addr_reg, fault_addr_next;
	logic [COUNT_W-1:0] trap_count_reg, trap_count_next;
	logic restart_reg, restart_next;
	mode_e mode_reg, mode_next;

	// output registers
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic mem_valid_reg, mem_valid_next;
	logic [31:0] mem_addr_reg, mem_addr_next;
	access_kind_e mem_kind_reg, mem_kind_next;
	logic acc_fault_reg, acc_fault_next;
	logic trap_req_reg, trap_req_next;
	trap_cause_e trap_cause_reg, trap_cause_next;
	logic [31:0] trap_ptr_reg, trap_ptr_next;
	logic resume_reg, resume_next;
	logic [31:0] resume_wdesc_reg, resume_wdesc_next;

	// apb decode
	wire setup = psel && !penable;
	wire wr_take = psel && penable && pready_reg && pwrite;
	wire hit_region = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
	wire [1:0] region_sel = paddr[3:2];
	wire hit_ptr = paddr == `OFF_STATE_PTR;
	wire hit_wdesc = paddr == `OFF_SUP_WDESC;
	wire hit_ctrl = paddr == `OFF_CONTROL;
	wire hit_status = paddr == `OFF_STATUS;
	wire hit_fault = paddr == `OFF_FAULT_ADDR;
	wire hit_count = paddr == `OFF_TRAP_COUNT;
	wire hit_any = hit_region || hit_ptr || hit_wdesc || hit_ctrl || hit_status
		|| hit_fault || hit_count;
	wire wr_ok = wr_take && hit_any;
	wire go_write = wr_ok && hit_ctrl && pstrb[0] && pwdata[`CTRL_GO_BIT];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// read data mux
	wire [31:0] status_word = (32'(mode_reg) << `STAT_MODE_LO)
		| (32'(trap_cause_reg) << `STAT_CAUSE_LO)
		| (32'(restart_reg) << `STAT_RESTART_BIT);
	wire [31:0] rd_mux = hit_region ? desc_reg[region_sel] :
		hit_ptr ? state_ptr_reg :
		hit_wdesc ? sup_wdesc_reg :
		hit_status ? status_word :
		hit_fault ? fault_addr_reg :
		hit_count ? 32'(trap_count_reg) : 32'h0000_0000;

	// access check, same cycle as the request
	logic chk_legal;
	trap_cause_e chk_cause;
	logic [31:0] chk_phys;
	logic ws_legal;
	trap_cause_e ws_cause;

	region_check u_access_check (
		.addr(acc_addr),
		.kind(acc_kind),
		.descs(desc_reg),
		.legal(chk_legal),
		.cause(chk_cause),
		.phys(chk_phys)
	);

	region_check u_workspace_check (
		.addr(workspace_pointer),
		.kind(ACC_WRITE),
		.descs(desc_reg),
		.legal(ws_legal),
		.cause(ws_cause),
		.phys()
	);

	wire in_prot = mode_reg == ST_PROTECTED;
	wire acc_bad = in_prot && acc_valid && !chk_legal; // RQ17
	wire ws_bad = in_prot && ws_check_valid && !ws_legal; // RQ19
	wire dbg_any = in_prot && (breakpoint_jump || step_done || watch_write); // RQ16
	wire trap_now = acc_bad || ws_bad || dbg_any;

	// cause priority: access fault, stack, breakpoint, step, watch
	wire trap_cause_e new_cause = acc_bad ? chk_cause :
		ws_bad ? CAUSE_STACK :
		breakpoint_jump ? CAUSE_BREAK :
		step_done ? CAUSE_STEP : CAUSE_WATCH;
	wire [31:0] new_fault_addr = acc_bad ? acc_addr :
		ws_bad ? workspace_pointer : fault_addr_reg;

	// register file next state
	always_comb begin
		desc_next = desc_reg;
		state_ptr_next = state_ptr_reg;
		sup_wdesc_next = sup_wdesc_reg;
		if (wr_ok && hit_region) begin
			desc_next[region_sel] = merge(desc_reg[region_sel], pwdata, pstrb); // RQ13
		end
		if (wr_ok && hit_ptr) begin
			state_ptr_next = merge(state_ptr_reg, pwdata, pstrb); // RQ14
		end
		if (wr_ok && hit_wdesc) begin
			sup_wdesc_next = merge(sup_wdesc_reg, pwdata, pstrb); // RQ15
		end
	end

	// apb answer: one wait-free access phase after each setup
	always_comb begin
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		if (setup) begin
			prdata_next = pwrite ? 32'h0000_0000 : rd_mux;
			pready_next = 1'b1;
			pslverr_next = !hit_any;
		end
	end

	// mode control and access forwarding
	always_comb begin
		mode_next = mode_reg;
		mem_valid_next = 1'b0;
		mem_addr_next = mem_addr_reg;
		mem_kind_next = mem_kind_reg;
		acc_fault_next = 1'b0;
		trap_req_next = trap_req_reg;
		trap_cause_next = trap_cause_reg;
		trap_ptr_next = trap_ptr_reg;
		resume_next = 1'b0;
		resume_wdesc_next = resume_wdesc_reg;
		fault_addr_next = fault_addr_reg;
		trap_count_next = trap_count_reg;
		restart_next = restart_reg;
		case (mode_reg)
			ST_SUPERVISOR: begin
				// supervisor accesses are already physical
				if (acc_valid) begin
					mem_valid_next = 1'b1;
					mem_addr_next = acc_addr;
					mem_kind_next = acc_kind;
				end
				if (go_write) begin
					mode_next = ST_PROTECTED;
					trap_cause_next = CAUSE_NONE;
					restart_next = 1'b0;
				end
			end
			ST_PROTECTED: begin
				if (acc_valid && chk_legal) begin // RQ20
					mem_valid_next = 1'b1;
					mem_addr_next = chk_phys;
					mem_kind_next = acc_kind;
				end
				acc_fault_next = acc_bad;
				if (trap_now) begin
					mode_next = ST_TRAPPED;
					trap_req_next = 1'b1;
					trap_cause_next = new_cause;
					trap_ptr_next = state_ptr_reg; // RQ14 RQ17
					fault_addr_next = new_fault_addr;
					restart_next = !acc_bad && ws_bad; // RQ19
					trap_count_next = trap_count_reg + COUNT_W'(1);
				end
			end
			ST_TRAPPED: begin
				// state is saved before the supervisor runs again
				if (state_saved) begin // RQ17
					mode_next = ST_SUPERVISOR;
					trap_req_next = 1'b0;
					resume_next = 1'b1; // RQ16
					resume_wdesc_next = sup_wdesc_reg; // RQ15
				end
			end
			default: begin
				mode_next = ST_SUPERVISOR;
				trap_req_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_reg <= {4{`DESC_RESET}};
			state_ptr_reg <= 32'h0000_0000;
			sup_wdesc_reg <= 32'h0000_0000;
			fault_addr_reg <= 32'h0000_0000;
			trap_count_reg <= '0;
			restart_reg <= 1'b0;
			mode_reg <= ST_SUPERVISOR;
		end else begin
			desc_reg <= desc_next;
			state_ptr_reg <= state_ptr_next;
			sup_wdesc_reg <= sup_wdesc_next;
			fault_addr_reg <= fault_addr_next;
			trap_count_reg <= trap_count_next;
			restart_reg <= restart_next;
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_valid_reg <= 1'b0;
			mem_addr_reg <= 32'h0000_0000;
			mem_kind_reg <= ACC_READ;
			acc_fault_reg <= 1'b0;
			trap_req_reg <= 1'b0;
			trap_cause_reg <= CAUSE_NONE;
			trap_ptr_reg <= 32'h0000_0000;
			resume_reg <= 1'b0;
			resume_wdesc_reg <= 32'h0000_0000;
		end else begin
			mem_valid_reg <= mem_valid_next;
			mem_addr_reg <= mem_addr_next;
			mem_kind_reg <= mem_kind_next;
			acc_fault_reg <= acc_fault_next;
			trap_req_reg <= trap_req_next;
			trap_cause_reg <= trap_cause_next;
			trap_ptr_reg <= trap_ptr_next;
			resume_reg <= resume_next;
			resume_wdesc_reg <= resume_wdesc_next;
		end
	end

	// protected flag registered alongside the mode
	logic prot_out_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_out_reg <= 1'b0;
		end else begin
			prot_out_reg <= mode_next == ST_PROTECTED;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign mem_valid = mem_valid_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_kind = mem_kind_reg;
	assign acc_fault = acc_fault_reg;
	assign protected_mode = prot_out_reg;
	assign trap_req = trap_req_reg;
	assign trap_cause = trap_cause_reg;
	assign trap_state_ptr = trap_ptr_reg;
	assign resume_supervisor = resume_reg;
	assign resume_wdesc = resume_wdesc_reg;
endmodule

// [rtl/region_protection_defines.svh]
// constants for the region protection and translation unit
// How it works
// (RQ1) top two address bits pick region
// (RQ2) each region uses only its descriptor
// (RQ3) only top or bottom block legal
// (RQ4) descriptor bit 0 permits writes
// (RQ5) descriptor bit 1 permits instruction fetches
// (RQ6) descriptor bit 2 places block at top
// (RQ7) lowest size marker bit n-1 gives size
// (RQ8) descriptor high bits replace logical high bits
// (RQ9) software never programs regions below 256 bytes
// (RQ10) null descriptor means zero size region
// (RQ11) software avoids other invalid descriptor encodings
// (RQ12) bits n to 29 must match position
// (RQ13) one 32-bit descriptor register per region
// (RQ14) keep pointer to saved state block
// (RQ15) keep supervisor workspace descriptor for resume
// (RQ16) debug events return control to supervisor
// (RQ17) illegal access traps after saving state
// (RQ18) reads allowed anywhere legal in region
// (RQ19) workspace pointer must be writable, restartable trap
// (RQ20) check and translate before memory side effect
`ifndef REGION_PROTECTION_DEFINES_SVH
`define REGION_PROTECTION_DEFINES_SVH

`define REGION_HI_BIT 31
`define REGION_LO_BIT 30
`define VALID_HI_BIT 29
`define DESC_WRITE_BIT 0
`define DESC_EXEC_BIT 1
`define DESC_TOP_BIT 2
`define SIZE_MARK_LO 7
`define MIN_SIZE_LOG2 8
`define MAX_SIZE_LOG2 30
`define DESC_NULL 32'h0800_0000
`define DESC_RESET 32'h0800_0000

`define OFF_REGION0 8'h00
`define OFF_REGION1 8'h04
`define OFF_REGION2 8'h08
`define OFF_REGION3 8'h0C
`define OFF_STATE_PTR 8'h10
`define OFF_SUP_WDESC 8'h14
`define OFF_CONTROL 8'h18
`define OFF_STATUS 8'h1C
`define OFF_FAULT_ADDR 8'h20
`define OFF_TRAP_COUNT 8'h24

`define CTRL_GO_BIT 0
`define STAT_MODE_LO 0
`define STAT_CAUSE_LO 4
`define STAT_RESTART_BIT 8

`endif

// [rtl/region_protection_pkg.sv]
// types shared by the region protection unit
package region_protection_pkg;
	typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_FETCH} access_kind_e;
	typedef enum logic [3:0] {
		CAUSE_NONE, CAUSE_RANGE, CAUSE_WRITE, CAUSE_FETCH,
		CAUSE_STACK, CAUSE_BREAK, CAUSE_STEP, CAUSE_WATCH
	} trap_cause_e;
	typedef enum logic [1:0] {ST_SUPERVISOR, ST_PROTECTED, ST_TRAPPED} mode_e;
endpackage

// [rtl/region_check.sv]
// combinational region selection, validity, permission and translation
`include "region_protection_defines.svh"
module region_check
	import region_protection_pkg::*;
#(
	parameter int MIN_LOG2 = `MIN_SIZE_LOG2,
	parameter int MAX_LOG2 = `MAX_SIZE_LOG2
) (
	input wire logic [31:0] addr, // logical address
	input wire access_kind_e kind, // read, write or fetch
	input wire logic [3:0][31:0] descs, // the four region descriptors
	output logic legal, // access may proceed
	output trap_cause_e cause, // reason when not legal
	output logic [31:0] phys // translated address
);
	if (MIN_LOG2 < `MIN_SIZE_LOG2 || MAX_LOG2 > `MAX_SIZE_LOG2 || MIN_LOG2 > MAX_LOG2) begin : g_bad
		$error("region_check: size limits out of range");
	end

	logic [3:0] size_ok;
	logic [3:0][31:0] low_mask;

	for (genvar r = 0; r < 4; r++) begin : g_reg
		logic [5:0] n;
		logic found;
		always_comb begin
			n = 6'h0;
			found = 1'b0;
			for (int k = `SIZE_MARK_LO; k < 32; k++) begin
				if (!found && descs[r][k]) begin // RQ7
					n = 6'(k + 1);
					found = 1'b1;
				end
			end
		end
		// null or out-of-range size markers give a region with no legal address
		assign size_ok[r] = found && (n >= 6'(MIN_LOG2)) && (n <= 6'(MAX_LOG2))
			&& (descs[r] != `DESC_NULL); // RQ10
		assign low_mask[r] = (32'h1 << n) - 32'h1;
	end

	wire [1:0] idx = addr[`REGION_HI_BIT:`REGION_LO_BIT]; // RQ1
	wire [31:0] sel_desc = descs[idx]; // RQ2
	wire [31:0] sel_low = low_mask[idx];
	wire sel_ok = size_ok[idx];
	wire [29:0] hi_bits = ~sel_low[`VALID_HI_BIT:0];
	wire [29:0] field = addr[`VALID_HI_BIT:0] & hi_bits;
	wire is_top = sel_desc[`DESC_TOP_BIT]; // RQ6
	wire in_block = is_top ? (field == hi_bits) : (field == 30'h0); // RQ3 RQ12
	wire wr_ok = sel_desc[`DESC_WRITE_BIT]; // RQ4
	wire ex_ok = sel_desc[`DESC_EXEC_BIT]; // RQ5

	assign phys = (sel_desc & ~sel_low) | (addr & sel_low); // RQ8

	always_comb begin
		legal = 1'b0;
		cause = CAUSE_RANGE;
		if (sel_ok && in_block) begin
			case (kind)
				ACC_READ: begin // RQ18
					legal = 1'b1;
					cause = CAUSE_NONE;
				end
				ACC_WRITE: begin
					legal = wr_ok;
					cause = wr_ok ? CAUSE_NONE : CAUSE_WRITE;
				end
				ACC_FETCH: begin
					legal = ex_ok;
					cause = ex_ok ? CAUSE_NONE : CAUSE_FETCH;
				end
				default: begin
					legal = 1'b0;
					cause = CAUSE_RANGE;
				end
			endcase
		end
	end
endmodule

// [dv/region_protection_translation_chk.sv]
// port assertions for the region protection unit
module region_protection_translation_chk
	import region_protection_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic acc_valid, // access request
	input wire logic [31:0] acc_addr, // logical address
	input wire access_kind_e acc_kind, // access kind
	input wire logic breakpoint_jump, // breakpoint pulse
	input wire logic state_saved, // save done pulse
	input wire logic mem_valid, // forwarded access
	input wire logic [31:0] mem_addr, // physical address
	input wire access_kind_e mem_kind, // forwarded kind
	input wire logic acc_fault, // refused access
	input wire logic protected_mode, // protected running
	input wire logic trap_req, // trap pending
	input wire trap_cause_e trap_cause, // trap reason
	input wire logic [31:0] trap_state_ptr, // save pointer
	input wire logic resume_supervisor // resume pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_prot_acc;
		protected_mode && acc_valid;
	endsequence
	sequence s_trapped;
		trap_req && !protected_mode;
	endsequence
	property p_answer;
		s_prot_acc |=> mem_valid != acc_fault;
	endproperty
	a_answer: assert property (p_answer)
		else $error("protected access not answered exactly once");
	property p_fault;
		acc_fault |-> s_trapped;
	endproperty
	a_fault: assert property (p_fault)
		else $error("refused access without trap");
	property p_low;
		mem_valid |-> mem_addr[7:0] == $past(acc_addr[7:0]) && mem_kind == $past(acc_kind);
	endproperty
	a_low: assert property (p_low)
		else $error("low address bits or kind altered");
	property p_read;
		s_prot_acc ##0 acc_kind == ACC_READ |=> !acc_fault || trap_cause == CAUSE_RANGE;
	endproperty
	a_read: assert property (p_read)
		else $error("read refused for permission");
	property p_write;
		s_prot_acc ##0 acc_kind == ACC_WRITE |=>
			!acc_fault || trap_cause inside {CAUSE_RANGE, CAUSE_WRITE};
	endproperty
	a_write: assert property (p_write)
		else $error("write refused with wrong cause");
	property p_fetch;
		s_prot_acc ##0 acc_kind == ACC_FETCH |=>
			!acc_fault || trap_cause inside {CAUSE_RANGE, CAUSE_FETCH};
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch refused with wrong cause");
	property p_break;
		protected_mode && breakpoint_jump && !acc_valid |=> s_trapped ##0 trap_cause == CAUSE_BREAK;
	endproperty
	a_break: assert property (p_break)
		else $error("breakpoint did not trap");
	property p_hold;
		trap_req && !state_saved |=> trap_req && $stable(trap_state_ptr);
	endproperty
	a_hold: assert property (p_hold)
		else $error("trap dropped or pointer moved before save");
	property p_release;
		trap_req && state_saved |=> !trap_req && resume_supervisor ##1 !resume_supervisor;
	endproperty
	a_release: assert property (p_release)
		else $error("supervisor not resumed by one pulse");
endmodule

// [dv/core_model.sv]
// core model: issues logical accesses and saves state on traps
module core_model
	import region_protection_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic trap_req, // trap from unit
	output logic acc_valid, // access request
	output logic [31:0] acc_addr, // logical address
	output access_kind_e acc_kind, // access kind
	output logic state_saved // save done pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	int save_delay = 0;
	int wait_cnt = 0;
	initial begin
		acc_valid = 0;
		acc_addr = 0;
		acc_kind = ACC_READ;
		state_saved = 0;
	end
	// one cycle request, address scrambled once released
	task access(input logic [31:0] a, input access_kind_e k);
		acc_valid <= 1;
		acc_addr <= a;
		acc_kind <= k;
		@(posedge pclk);
		acc_valid <= 0;
		acc_addr <= ~a;
	endtask
	// saving takes save_delay cycles, then one pulse per trap
	always @(posedge pclk) begin
		if (trap_req === 1'b1 && !state_saved) begin
			if (wait_cnt >= save_delay) begin
				state_saved <= 1;
				wait_cnt <= 0;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end else begin
			state_saved <= 0;
		end
	end
endmodule

// [dv/testbench.sv]
// self-checking bench for the region protection unit
module testbench import region_protection_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic acc_valid, ws_check_valid, state_saved, mem_valid, acc_fault;
	logic protected_mode, trap_req, resume_supervisor;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [2:0] dbg;
	logic [31:0] pwdata, prdata, workspace_pointer, mem_addr, trap_state_ptr, resume_wdesc;
	logic [31:0] acc_addr, rd, ssp, swd, a;
	logic [31:0] desc_m [4];
	logic [32:0] e;
	access_kind_e acc_kind, mem_kind, k;
	trap_cause_e trap_cause;
	int n_fail = 0, num_checks = 0, seed = 24, cyc = 0;
	region_protection_translation dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
		.acc_addr(acc_addr), .acc_kind(acc_kind), .ws_check_valid(ws_check_valid),
		.workspace_pointer(workspace_pointer), .breakpoint_jump(dbg[0]), .step_done(dbg[1]),
		.watch_write(dbg[2]), .state_saved(state_saved), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .mem_kind(mem_kind), .acc_fault(acc_fault),
		.protected_mode(protected_mode), .trap_req(trap_req), .trap_cause(trap_cause),
		.trap_state_ptr(trap_state_ptr), .resume_supervisor(resume_supervisor),
		.resume_wdesc(resume_wdesc));
	core_model core (.pclk(pclk), .trap_req(trap_req), .acc_valid(acc_valid),
		.acc_addr(acc_addr), .acc_kind(acc_kind), .state_saved(state_saved));
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_fail++;
			give_verdict;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
		int t;
		t = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 20) begin
			@(posedge pclk);
			t++;
		end
		if (t == 20) n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// idle edge so the next setup never reassigns psel in this time step
		@(posedge pclk);
	endtask
	task go;
		apb(1, 8'h18, 32'h1, 4'hF);
		@(posedge pclk);
		check(protected_mode, 1);
	endtask
	// CAUSE_NONE means any cause is acceptable
	task trap_done(input trap_cause_e c);
		int t;
		t = 0;
		check(trap_req, 1);
		if (c != CAUSE_NONE) check(trap_cause, c);
		check(trap_state_ptr, ssp);
		while (resume_supervisor !== 1'b1 && t < 30) begin
			@(posedge pclk);
			t++;
		end
		check(resume_supervisor, 1);
		check(resume_wdesc, swd);
	endtask
	function automatic logic [32:0] xlate(input logic [31:0] ad, input access_kind_e kd);
		logic [31:0] d, m;
		int n;
		logic ok;
		d = desc_m[ad[31:30]];
		n = 0;
		for (int i = 31; i >= 7; i--) if (d[i]) n = i + 1;
		m = (32'h1 << n) - 32'h1;
		ok = d != 32'h0800_0000 && n >= 8 && n <= 30;
		for (int i = 8; i < 30; i++) if (i >= n && ad[i] != d[2]) ok = 0;
		if (kd == ACC_WRITE && !d[0]) ok = 0;
		if (kd == ACC_FETCH && !d[1]) ok = 0;
		return {ok, (d & ~m) | (ad & m)};
	endfunction
	function logic [31:0] rand_desc;
		int n;
		logic [31:0] d;
		n = 8 + ($unsigned($random(seed)) % 23);
		d = $random(seed);
		d = d & ~((32'h1 << n) - 32'h1);
		d[n - 1] = 1;
		d[2:0] = 3'($random(seed));
		if ($unsigned($random(seed)) % 8 == 0) d = 32'h0800_0000;
		return d;
	endfunction
	function logic [31:0] rand_addr;
		logic [31:0] ad, x, hi;
		ad = $random(seed);
		x = desc_m[ad[31:30]] & 32'hFFFF_FF80;
		hi = 32'h3FFF_FFFF & ~(((x & (~x + 32'h1)) << 1) - 32'h1);
		if ($unsigned($random(seed)) % 4 != 0) ad = desc_m[ad[31:30]][2] ? ad | hi : ad & ~hi;
		return ad;
	endfunction
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		pstrb = 0;
		ws_check_valid = 0;
		workspace_pointer = 0;
		dbg = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int r = 0; r < 4; r++) begin
			apb(0, 8'(4 * r), 0, 0);
			check(rd, 32'h0800_0000);
		end
		apb(0, 8'h40, 0, 0);
		check(err, 1);
		apb(1, 8'h04, 32'hFFFF_FFFF, 4'h1);
		apb(0, 8'h04, 0, 0);
		check(rd, 32'h0800_00FF);
		// supervisor accesses pass untranslated
		core.access(32'hC000_1234, ACC_FETCH);
		@(posedge pclk);
		check(mem_valid, 1);
		check(mem_addr, 32'hC000_1234);
		check(mem_kind, ACC_FETCH);
		$display("test registers done");
		for (int round = 0; round < 4; round++) begin
			core.save_delay = round * 3;
			ssp = $random(seed);
			swd = $random(seed);
			apb(1, 8'h10, ssp, 4'hF);
			apb(1, 8'h14, swd, 4'hF);
			for (int r = 0; r < 4; r++) begin
				desc_m[r] = rand_desc();
				apb(1, 8'(4 * r), desc_m[r], 4'hF);
			end
			apb(0, 8'h08, 0, 0);
			check(rd, desc_m[2]);
			go;
			for (int i = 0; i < 16; i++) begin
				a = rand_addr();
				k = access_kind_e'($unsigned($random(seed)) % 3);
				e = xlate(a, k);
				core.access(a, k);
				@(posedge pclk);
				check(mem_valid, e[32]);
				check(acc_fault, !e[32]);
				if (e[32]) begin
					check(mem_addr, e[31:0]);
				end else begin
					if (xlate(a, ACC_READ) !== e)
						trap_done(k == ACC_WRITE ? CAUSE_WRITE : CAUSE_FETCH);
					else
						trap_done(CAUSE_RANGE);
					go;
				end
			end
			$display("test round %0d done", round);
		end
		desc_m[0] = 32'h0000_0080;
		apb(1, 8'h00, desc_m[0], 4'hF);
		for (int i = 0; i < 3; i++) begin
			go;
			dbg <= 3'(1 << i);
			@(posedge pclk);
			dbg <= 0;
			@(posedge pclk);
			trap_done(i == 0 ? CAUSE_BREAK : i == 1 ? CAUSE_STEP : CAUSE_WATCH);
		end
		$display("test debug done");
		go;
		workspace_pointer <= 32'h0000_0010;
		ws_check_valid <= 1;
		@(posedge pclk);
		ws_check_valid <= 0;
		@(posedge pclk);
		trap_done(CAUSE_STACK);
		apb(0, 8'h1C, 0, 0);
		check(rd[8], 1);
		apb(1, 8'h00, 32'h0000_0081, 4'hF);
		go;
		ws_check_valid <= 1;
		@(posedge pclk);
		ws_check_valid <= 0;
		@(posedge pclk);
		check(trap_req, 0);
		check(protected_mode, 1);
		$display("test workspace done");
		give_verdict;
	end
endmodule
bind region_protection_translation region_protection_translation_chk chk (.pclk(pclk),
	.presetn(presetn), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
	.breakpoint_jump(breakpoint_jump), .state_saved(state_saved), .mem_valid(mem_valid),
	.mem_addr(mem_addr), .mem_kind(mem_kind), .acc_fault(acc_fault),
	.protected_mode(protected_mode), .trap_req(trap_req), .trap_cause(trap_cause),
	.trap_state_ptr(trap_state_ptr), .resume_supervisor(resume_supervisor));
